// ---- rtl/aec_regs.sv ----
// extended control register bank, top level
// assumes: host writes 32-bit frames on the three-wire link,
// control pins are asynchronous to the core clock
//
// Behaviour
// R1 - the 4-bit address follows the header msb first and only 1h,2h,3h,Ah,Bh,Dh,Eh,Fh select registers.
// R2 - all registers are write-only and have no effect while the device is in pin-based normal mode.
// R3 - the host writes configuration bit 15 as one, bit 14 as zero, bit 13 as one and bits 7..0 as ones.
// R4 - configuration bit 12 turns the duty-cycle stabilizer on when one and off when zero.
// R5 - configuration bit 11 picks 0 or 90 degree output clock phase, acts only in double rate, resets to zero.
// R6 - configuration bit 10 picks double rate at zero and single rate at one, and resets to zero.
// R7 - configuration bit 9 picks the standard swing at one and the reduced swing at zero, and resets to one.
// R8 - configuration bit 8 picks rising output edge at one and falling at zero in single rate, reset zero.
// R9 - offset bits 15..8 hold an unsigned magnitude that resets to zero.
// R10 - offset bit 7 is the sign, zero positive and one negative, resetting to zero.
// R11 - the host writes offset bits 6..0 as ones.
// R12 - the offset register holds 007Fh after reset.
// R13 - a frame is 32 bits msb first: header of eleven zeros and a one, 4 address bits, 16 data bits.
// R14 - select is held low during an access and data is sampled on rising shift clock edges.
// R15 - a new frame may follow on the 33rd shift clock, and the link acts only in extended mode.
// R16 - frames with a bad header or reserved address are dropped, and a register changes only after bit 32.
`timescale 1ns/1ps
module aec_regs (
  // core clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // serial link
  input wire logic serial_clk_in,
  input wire logic serial_in,
  input wire logic serial_select_n_in,
  // control pins
  input wire logic extended_control_pin_in,
  input wire logic edge_select_pin_in,
  input wire logic swing_select_pin_in,
  // output format controls
  output logic extended_mode_out,
  output logic duty_stabilizer_en_out,
  output logic ddr_clock_phase_out,
  output logic single_rate_select_out,
  output logic output_swing_select_out,
  output logic data_edge_select_out,
  // offset controls
  output logic [7:0] i_offset_mag_out,
  output logic i_offset_neg_out,
  // raw trims
  output logic [15:0] i_fullscale_trim_out,
  output logic [15:0] q_offset_trim_out,
  output logic [15:0] q_fullscale_trim_out,
  output logic [15:0] interleave_enable_out,
  output logic [15:0] interleave_coarse_delay_out,
  output logic [15:0] interleave_fine_delay_out
);
  // ==========================================
  // link side and crossing
  aec_frame_if frm_if ();
  logic frame_valid;
  logic [31:0] frame_word;

  aec_serial_rx u_rx (
    .serial_clk_in(serial_clk_in),
    .rst_b_in(rst_b_in),
    .serial_in(serial_in),
    .serial_select_n_in(serial_select_n_in),
    .frm(frm_if.link_side)
  );

  aec_frame_cdc u_cdc (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .frm(frm_if.core_side),
    .frame_valid_out(frame_valid),
    .frame_word_out(frame_word)
  );

  // ==========================================
  // pin synchronisers
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic ext_mode;
  logic edge_pin;
  logic swing_pin;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {extended_control_pin_in, edge_select_pin_in, swing_select_pin_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign ext_mode = pin_s2_reg[2];
  assign edge_pin = pin_s2_reg[1];
  assign swing_pin = pin_s2_reg[0];

  // ==========================================
  // frame decode
  logic [11:0] hdr;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic hdr_ok;
  logic [aec_pkg::NUM_REGS-1:0] hit_vec;
  logic wr_ok;

  assign hdr = frame_word[aec_pkg::HDR_MSB:aec_pkg::HDR_LSB];
  assign addr = frame_word[aec_pkg::ADR_MSB:aec_pkg::ADR_LSB]; // [R1]
  assign wdata = frame_word[15:0];
  assign hdr_ok = hdr == aec_pkg::HEADER; // [R13]
  // frames arriving in normal mode are thrown away
  assign wr_ok = frame_valid && ext_mode && hdr_ok && (|hit_vec); // [R15] [R16]

  // ==========================================
  // register storage
  // no read path: software cannot see the bank, so data
  // bits the host must fix are stored exactly as sent
  aec_pkg::aec_word_t reg_q [aec_pkg::NUM_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < aec_pkg::NUM_REGS; gi++) begin : g_reg
      assign hit_vec[gi] = addr == aec_pkg::REG_ADDR[gi]; // [R1]
      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          reg_q[gi] <= aec_pkg::REG_RST[gi]; // [R12]
        end else if (wr_ok && hit_vec[gi]) begin
          reg_q[gi] <= wdata; // [R16]
        end
      end
    end
  endgenerate

  // ==========================================
  // output format controls
  logic [15:0] cfg;
  assign cfg = reg_q[aec_pkg::IDX_CFG];

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      extended_mode_out <= 1'b0;
      duty_stabilizer_en_out <= 1'b1;
      ddr_clock_phase_out <= 1'b0;
      single_rate_select_out <= 1'b0;
      output_swing_select_out <= 1'b1;
      data_edge_select_out <= 1'b0;
    end else if (ext_mode) begin
      extended_mode_out <= 1'b1;
      duty_stabilizer_en_out <= cfg[aec_pkg::CFG_DCS_BIT]; // [R4]
      // phase only matters in double rate
      ddr_clock_phase_out <= cfg[aec_pkg::CFG_DCP_BIT] & ~cfg[aec_pkg::CFG_SDR_BIT]; // [R5]
      single_rate_select_out <= cfg[aec_pkg::CFG_SDR_BIT]; // [R6]
      output_swing_select_out <= cfg[aec_pkg::CFG_SWING_BIT]; // [R7]
      data_edge_select_out <= cfg[aec_pkg::CFG_EDGE_BIT]; // [R8]
    end else begin
      // pin-based mode: register contents ignored
      extended_mode_out <= 1'b0;
      duty_stabilizer_en_out <= 1'b1; // [R2]
      ddr_clock_phase_out <= 1'b0; // [R2]
      single_rate_select_out <= 1'b0;
      output_swing_select_out <= swing_pin;
      data_edge_select_out <= edge_pin;
    end
  end

  // ==========================================
  // offset and trim outputs
  logic [15:0] ioff;
  assign ioff = reg_q[aec_pkg::IDX_IOFF];

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      i_offset_mag_out <= 8'h00;
      i_offset_neg_out <= 1'b0;
      i_fullscale_trim_out <= aec_pkg::REG_RST[aec_pkg::IDX_IFS];
      q_offset_trim_out <= aec_pkg::REG_RST[aec_pkg::IDX_QOFF];
      q_fullscale_trim_out <= aec_pkg::REG_RST[aec_pkg::IDX_QFS];
      interleave_enable_out <= aec_pkg::REG_RST[aec_pkg::IDX_ILV_EN];
      interleave_coarse_delay_out <= aec_pkg::REG_RST[aec_pkg::IDX_ILV_CRS];
      interleave_fine_delay_out <= aec_pkg::REG_RST[aec_pkg::IDX_ILV_FINE];
    end else if (ext_mode) begin
      i_offset_mag_out <= ioff[aec_pkg::OFF_MAG_MSB:aec_pkg::OFF_MAG_LSB]; // [R9]
      i_offset_neg_out <= ioff[aec_pkg::OFF_SIGN_BIT]; // [R10]
      i_fullscale_trim_out <= reg_q[aec_pkg::IDX_IFS];
      q_offset_trim_out <= reg_q[aec_pkg::IDX_QOFF];
      q_fullscale_trim_out <= reg_q[aec_pkg::IDX_QFS];
      interleave_enable_out <= reg_q[aec_pkg::IDX_ILV_EN];
      interleave_coarse_delay_out <= reg_q[aec_pkg::IDX_ILV_CRS];
      interleave_fine_delay_out <= reg_q[aec_pkg::IDX_ILV_FINE];
    end else begin
      // no offset adjust without the serial bank
      i_offset_mag_out <= 8'h00; // [R2]
      i_offset_neg_out <= 1'b0;
      i_fullscale_trim_out <= aec_pkg::REG_RST[aec_pkg::IDX_IFS];
      q_offset_trim_out <= aec_pkg::REG_RST[aec_pkg::IDX_QOFF];
      q_fullscale_trim_out <= aec_pkg::REG_RST[aec_pkg::IDX_QFS];
      interleave_enable_out <= aec_pkg::REG_RST[aec_pkg::IDX_ILV_EN];
      interleave_coarse_delay_out <= aec_pkg::REG_RST[aec_pkg::IDX_ILV_CRS];
      interleave_fine_delay_out <= aec_pkg::REG_RST[aec_pkg::IDX_ILV_FINE];
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // outputs are registered, so most checks look one core cycle back

  logic [15:0] cfg_prev;
  logic [15:0] ioff_prev;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_prev <= aec_pkg::REG_RST[aec_pkg::IDX_CFG];
      ioff_prev <= aec_pkg::REG_RST[aec_pkg::IDX_IOFF];
    end else begin
      cfg_prev <= cfg;
      ioff_prev <= ioff;
    end
  end

  chk_bad_header: assert property ( // [R16]
    frame_valid && !hdr_ok |=> cfg == cfg_prev && ioff == ioff_prev)
    else $error("bad header changed a register");

  chk_reserved_addr: assert property ( // [R1]
    frame_valid && !(|hit_vec) |=> cfg == cfg_prev && ioff == ioff_prev)
    else $error("reserved address changed a register");

  chk_cfg_write: assert property ( // [R13]
    frame_valid && ext_mode && hdr_ok && addr == aec_pkg::REG_ADDR[aec_pkg::IDX_CFG]
    |=> cfg == $past(wdata))
    else $error("config write not stored");

  chk_normal_ignore: assert property ( // [R2]
    !ext_mode ##1 !ext_mode |-> !ddr_clock_phase_out && i_offset_mag_out == 8'h00
      && duty_stabilizer_en_out)
    else $error("register acted in normal mode");

  chk_link_gated: assert property ( // [R15]
    frame_valid && !ext_mode |=> cfg == cfg_prev && ioff == ioff_prev)
    else $error("write taken in normal mode");

  chk_dcs_follow: assert property ( // [R4]
    ext_mode |=> duty_stabilizer_en_out == $past(cfg[aec_pkg::CFG_DCS_BIT]))
    else $error("stabilizer enable wrong");

  chk_phase_ddr: assert property ( // [R5]
    ddr_clock_phase_out |-> !single_rate_select_out)
    else $error("phase set in single rate");

  chk_rate_follow: assert property ( // [R6]
    ext_mode |=> single_rate_select_out == $past(cfg[aec_pkg::CFG_SDR_BIT]))
    else $error("rate select wrong");

  chk_swing_follow: assert property ( // [R7]
    ext_mode |=> output_swing_select_out == $past(cfg[aec_pkg::CFG_SWING_BIT]))
    else $error("swing select wrong");

  chk_edge_follow: assert property ( // [R8]
    ext_mode |=> data_edge_select_out == $past(cfg[aec_pkg::CFG_EDGE_BIT]))
    else $error("edge select wrong");

  chk_offset_out: assert property ( // [R9]
    ext_mode |=> i_offset_mag_out == $past(ioff[aec_pkg::OFF_MAG_MSB:aec_pkg::OFF_MAG_LSB])
      && i_offset_neg_out == $past(ioff[aec_pkg::OFF_SIGN_BIT]))
    else $error("offset output wrong");

  chk_offset_rst: assert property ( // [R12]
    $past(rst_b_in) == 1'b0 |-> ioff == aec_pkg::REG_RST[aec_pkg::IDX_IOFF]
      && cfg == aec_pkg::REG_RST[aec_pkg::IDX_CFG])
    else $error("reset value wrong");

  chk_ioff_write: assert property ( // [R16]
    frame_valid && ext_mode && hdr_ok && addr == aec_pkg::REG_ADDR[aec_pkg::IDX_IOFF]
    |=> ioff == $past(wdata))
    else $error("offset write not stored");

  chk_pins_normal: assert property ( // [R7]
    !ext_mode |=> output_swing_select_out == $past(swing_pin) && data_edge_select_out == $past(edge_pin))
    else $error("normal mode pins not followed");

  chk_trims_normal: assert property ( // [R2]
    !ext_mode |=> i_fullscale_trim_out == aec_pkg::REG_RST[aec_pkg::IDX_IFS]
      && q_offset_trim_out == aec_pkg::REG_RST[aec_pkg::IDX_QOFF]
      && interleave_enable_out == aec_pkg::REG_RST[aec_pkg::IDX_ILV_EN]
      && !i_offset_neg_out && !single_rate_select_out)
    else $error("trims acted in normal mode");

  chk_trims_follow: assert property ( // [R16]
    ext_mode |=> q_offset_trim_out == $past(reg_q[aec_pkg::IDX_QOFF])
      && interleave_fine_delay_out == $past(reg_q[aec_pkg::IDX_ILV_FINE])
      && i_fullscale_trim_out == $past(reg_q[aec_pkg::IDX_IFS]))
    else $error("stored trim not passed out");

  chk_mode_follow: assert property ( // [R15]
    ext_mode |=> extended_mode_out)
    else $error("extended mode not shown");

  cov_cfg_write: cover property (wr_ok && hit_vec[aec_pkg::IDX_CFG]);
  cov_ioff_write: cover property (wr_ok && hit_vec[aec_pkg::IDX_IOFF]);
  cov_reserved: cover property (frame_valid && hdr_ok && !(|hit_vec));
  cov_back_to_back: cover property (wr_ok ##[1:6] wr_ok);
  cov_normal_drop: cover property (frame_valid && !ext_mode);
endmodule

// ---- rtl/aec_pkg.sv ----
// constants of the extended control register bank
// assumes: 16-bit registers, 32-bit write frames
package aec_pkg;
  // ==========================================
  // frame layout
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [11:0] HEADER = 12'h001;
  localparam int unsigned HDR_MSB = 31;
  localparam int unsigned HDR_LSB = 20;
  localparam int unsigned ADR_MSB = 19;
  localparam int unsigned ADR_LSB = 16;
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================
  // register map
  typedef logic [15:0] aec_word_t;
  localparam int unsigned NUM_REGS = 8;
  localparam int unsigned IDX_CFG = 0;
  localparam int unsigned IDX_IOFF = 1;
  localparam int unsigned IDX_IFS = 2;
  localparam int unsigned IDX_QOFF = 3;
  localparam int unsigned IDX_QFS = 4;
  localparam int unsigned IDX_ILV_EN = 5;
  localparam int unsigned IDX_ILV_CRS = 6;
  localparam int unsigned IDX_ILV_FINE = 7;
  localparam logic [3:0] REG_ADDR [NUM_REGS] = '{
    4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
  localparam aec_word_t REG_RST [NUM_REGS] = '{
    16'hb2ff, 16'h007f, 16'h807f, 16'h007f,
    16'h807f, 16'h3fff, 16'h07ff, 16'h007f};

  // ==========================================
  // field positions
  localparam int unsigned CFG_DCS_BIT = 12;
  localparam int unsigned CFG_DCP_BIT = 11;
  localparam int unsigned CFG_SDR_BIT = 10;
  localparam int unsigned CFG_SWING_BIT = 9;
  localparam int unsigned CFG_EDGE_BIT = 8;
  localparam int unsigned OFF_MAG_MSB = 15;
  localparam int unsigned OFF_MAG_LSB = 8;
  localparam int unsigned OFF_SIGN_BIT = 7;
endpackage

// ---- rtl/aec_frame_if.sv ----
// carries a finished write frame from the link side
// assumes: word stays put until the next toggle
`timescale 1ns/1ps
interface aec_frame_if;
  logic [31:0] frame_word;
  logic frame_toggle;
  modport link_side (output frame_word, output frame_toggle);
  modport core_side (input frame_word, input frame_toggle);
endinterface

// ---- rtl/aec_serial_rx.sv ----
// three-wire link receiver, runs on the link clock
// assumes: host changes data away from rising shift edges
`timescale 1ns/1ps
module aec_serial_rx (
  // link
  input wire logic serial_clk_in,
  input wire logic rst_b_in,
  input wire logic serial_in,
  input wire logic serial_select_n_in,
  // frame out
  aec_frame_if.link_side frm
);
  // ==========================================
  // bit counting
  // select high clears the count without a shift edge,
  // since the shift clock may stop between frames
  logic rx_rst_b;
  logic [4:0] cnt_reg;
  logic [30:0] shift_reg;
  logic tog_reg;
  logic [31:0] word_reg;
  assign rx_rst_b = rst_b_in & ~serial_select_n_in;

  always_ff @(posedge serial_clk_in or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      cnt_reg <= 5'h00;
      shift_reg <= 31'h0000_0000;
    end else begin
      cnt_reg <= cnt_reg + 5'h01; // [R14] [R15]
      shift_reg <= {shift_reg[29:0], serial_in}; // [R13]
    end
  end

  // ==========================================
  // frame hand-off
  always_ff @(posedge serial_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tog_reg <= 1'b0;
      word_reg <= 32'h0000_0000;
    end else if (!serial_select_n_in && cnt_reg == aec_pkg::LAST_BIT) begin
      tog_reg <= ~tog_reg; // [R16]
      word_reg <= {shift_reg, serial_in}; // [R13]
    end
  end

  assign frm.frame_word = word_reg;
  assign frm.frame_toggle = tog_reg;

  chk_frame_len: assert property (@(posedge serial_clk_in) disable iff (!rx_rst_b) // [R13]
    tog_reg != $past(tog_reg) |-> $past(cnt_reg) == aec_pkg::LAST_BIT)
    else $error("frame closed before bit 32");
endmodule

// ---- rtl/aec_frame_cdc.sv ----
// brings finished frames into the core clock domain
// assumes: frames at least 32 link clocks apart
`timescale 1ns/1ps
module aec_frame_cdc (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // frame in
  aec_frame_if.core_side frm,
  // frame out
  output logic frame_valid_out,
  output logic [31:0] frame_word_out
);
  // ==========================================
  // toggle synchroniser
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic hit;
  assign hit = s2_reg ^ s3_reg;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= frm.frame_toggle;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ==========================================
  // word capture
  // word has been stable two core cycles when sampled here
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frame_valid_out <= 1'b0;
      frame_word_out <= 32'h0000_0000;
    end else begin
      frame_valid_out <= hit;
      if (hit) begin
        frame_word_out <= frm.frame_word;
      end
    end
  end
endmodule

// ---- verification/aec_host_model.sv ----
// host side of the three-wire write link
// assumes: the bench calls one task at a time, link clock idles low
`timescale 1ns/1ps
module aec_host_model (
  // link
  output logic serial_clk_out,
  output logic serial_out,
  output logic serial_select_n_out
);
  localparam time HALF = 6ns;

  initial begin
    serial_clk_out = 1'b0;
    serial_out = 1'b0;
    serial_select_n_out = 1'b1;
  end

  // ==========================================
  // frames
  // msb first, data set after a falling edge
  // keep_sel chains the next frame from the 33rd edge
  task automatic send_frame(input logic [31:0] word, input bit keep_sel, input int n_bits);
    for (int i = 0; i < n_bits; i++) begin
      serial_select_n_out = 1'b0;
      serial_out = word[31-i];
      #HALF serial_clk_out = 1'b1;
      #HALF serial_clk_out = 1'b0;
    end
    if (!keep_sel || n_bits < 32) begin
      serial_select_n_out = 1'b1;
      // released line must not keep showing the last bit
      serial_out = ~serial_out;
      // let select stand high for a while so a following frame never reasserts it in the same step
      #HALF;
    end
  endtask

  // a few edges with select high so the link side sees reset
  task automatic reset_clocks(input int n);
    repeat (n) begin
      #HALF serial_clk_out = 1'b1;
      #HALF serial_clk_out = 1'b0;
    end
  endtask
endmodule

// ---- verification/aec_regs_tb_top.sv ----
// self-checking bench for the extended control register bank
// assumes: host model drives the link, bench drives clock, reset and pins
`timescale 1ns/1ps
module aec_regs_tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ext_pin = 1'b0;
  logic edge_pin = 1'b0;
  logic swing_pin = 1'b1;
  logic sclk;
  logic sdat;
  logic ssel_n;
  logic ext_o, dcs_o, dcp_o, sdr_o, swing_o, edge_o, neg_o;
  logic [7:0] mag_o;
  logic [5:0][15:0] tr_o;
  logic [110:0] seen;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hd23f_c831;
  aec_pkg::aec_word_t mdl [8];
  logic [110:0] exp_q [$];
  event chk_ev;
  // must-be-one bits per register, host duty
  localparam logic [15:0] ONES [8] = '{16'ha0ff, 16'h007f, 16'h007f, 16'h007f,
    16'h007f, 16'h3fff, 16'h07ff, 16'h007f};

  always #50 core_clk = ~core_clk;

  aec_host_model host (.serial_clk_out(sclk), .serial_out(sdat), .serial_select_n_out(ssel_n));

  aec_regs uut (.core_clk_in(core_clk), .rst_b_in(rst_b), .serial_clk_in(sclk), .serial_in(sdat),
    .serial_select_n_in(ssel_n), .extended_control_pin_in(ext_pin), .edge_select_pin_in(edge_pin),
    .swing_select_pin_in(swing_pin), .extended_mode_out(ext_o), .duty_stabilizer_en_out(dcs_o),
    .ddr_clock_phase_out(dcp_o), .single_rate_select_out(sdr_o), .output_swing_select_out(swing_o),
    .data_edge_select_out(edge_o), .i_offset_mag_out(mag_o), .i_offset_neg_out(neg_o),
    .i_fullscale_trim_out(tr_o[5]), .q_offset_trim_out(tr_o[4]), .q_fullscale_trim_out(tr_o[3]),
    .interleave_enable_out(tr_o[2]), .interleave_coarse_delay_out(tr_o[1]),
    .interleave_fine_delay_out(tr_o[0]));

  assign seen = {ext_o, dcs_o, dcp_o, sdr_o, swing_o, edge_o, mag_o, neg_o, tr_o};

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int i = 0; i < 16; i++) r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r;
  endfunction

  function automatic int idx_of(input logic [3:0] a);
    for (int i = 0; i < 8; i++) if (aec_pkg::REG_ADDR[i] === a) return i;
    return -1;
  endfunction

  // phase only counts in double rate, normal mode ignores stored words
  function automatic logic [110:0] exp_bundle();
    logic [15:0] c;
    logic [15:0] o;
    c = mdl[0];
    o = mdl[1];
    if (ext_pin) return {1'b1, c[12], c[11] & ~c[10], c[10], c[9], c[8], o[15:8], o[7],
      mdl[2], mdl[3], mdl[4], mdl[5], mdl[6], mdl[7]};
    return {1'b0, 1'b1, 1'b0, 1'b0, swing_pin, edge_pin, 8'h00, 1'b0, aec_pkg::REG_RST[2],
      aec_pkg::REG_RST[3], aec_pkg::REG_RST[4], aec_pkg::REG_RST[5], aec_pkg::REG_RST[6],
      aec_pkg::REG_RST[7]};
  endfunction

  task automatic reset_model();
    foreach (mdl[i]) mdl[i] = aec_pkg::REG_RST[i];
    mdl[0] = 16'hb2ff;  // power-on format word
    mdl[1] = 16'h007f;  // power-on offset word
  endtask

  task automatic check(input logic [95:0] got, input logic [95:0] want);
    tests_run++;
    if (got !== want) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, want);
    end
  endtask

  task automatic note(input int n);
    repeat (n) @(negedge core_clk);
    exp_q.push_back(exp_bundle());
    ->chk_ev;
  endtask

  // a refused or cut frame leaves the model alone
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [11:0] hdr,
    input bit keep, input int n_bits);
    int k;
    k = idx_of(a);
    host.send_frame({hdr, a, d}, keep, n_bits);
    if (hdr === 12'h001 && k >= 0 && ext_pin && n_bits == 32) mdl[k] = d;
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks so far %0d", name, tests_run);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // output watcher
  initial begin
    logic [110:0] e;
    forever begin
      @(chk_ev);
      e = exp_q.pop_front();
      check(96'(seen[110]), 96'(e[110]));  // mode level
      check(96'(seen[109:105]), 96'(e[109:105]));  // format fields
      check(96'(seen[104:96]), 96'(e[104:96]));  // offset fields
      check(seen[95:0], e[95:0]);  // raw trims
    end
  end

  // whole run is well under a thousand cycles, this only catches a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    logic [15:0] d;
    logic [3:0] rsv [8];
    rsv = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc};
    reset_model();
    host.reset_clocks(2);
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = rnd(seed);
      edge_pin = seed[0];
      swing_pin = seed[1];
      note(4);
    end
    end_test("normal pins");
    ext_pin = 1'b1;
    note(4);
    end_test("reset values");
    for (int c = 0; c < 32; c++) begin
      wr(4'h1, {3'b101, 5'(c), 8'hff}, 12'h001, 1'b0, 32);
      note(8);
    end
    end_test("format fields");
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 8; k++) begin
        seed = rnd(seed);
        d = (seed[15:0] | ONES[k]) & ~((k == 0) ? 16'h4000 : 16'h0000);  // host fixed bits
        wr(aec_pkg::REG_ADDR[k], d, 12'h001, k < 7, 32);
      end
      note(8);
    end
    end_test("back to back");
    for (int i = 0; i < 8; i++) begin
      seed = rnd(seed);
      wr(rsv[i], seed[15:0], 12'h001, 1'b0, 32);
      note(8);
    end
    wr(4'h2, 16'hff7f, 12'h003, 1'b0, 32);
    wr(4'h2, 16'hff7f, 12'h000, 1'b0, 32);
    wr(4'h2, 16'hff7f, 12'h801, 1'b0, 32);
    note(8);
    wr(4'h2, 16'h55ff, 12'h001, 1'b0, 20);
    note(8);
    wr(4'h2, 16'h80ff, 12'h001, 1'b0, 32);
    note(8);
    end_test("refused frames");
    ext_pin = 1'b0;
    note(4);
    wr(4'h1, 16'hbeff, 12'h001, 1'b0, 32);
    note(8);
    ext_pin = 1'b1;
    note(4);
    end_test("mode switch");
    rst_b = 1'b0;
    host.reset_clocks(2);
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    reset_model();
    note(4);
    end_test("second reset");
    summarize();
  end
endmodule
